/* File: include/ddrsc_map.svh */
// bus widths, lane counts and sizes for the burst-of-two sram front end
`ifndef DDRSC_MAP_SVH
`define DDRSC_MAP_SVH
`define DDRSC_DATA_W 36
`define DDRSC_LANES 4
`define DDRSC_LANE_W 9
`define DDRSC_ADDR_W 22
`define DDRSC_ROW_W 22
`define DDRSC_ADDR_W36 21
`define DDRSC_BURST_LEN 2
`define DDRSC_FIFO_DEPTH 4
`endif

/* File: include/ddrsc_pkg.sv */
// types shared by the sram front end
`include "ddrsc_map.svh"
package ddrsc_pkg;
  typedef enum logic [1:0] {
    DDRSC_ORG_X8 = 2'b00,
    DDRSC_ORG_X9 = 2'b01,
    DDRSC_ORG_X18 = 2'b10,
    DDRSC_ORG_X36 = 2'b11
  } ddrsc_org_t;

  typedef enum logic {
    DDRSC_ST_IDLE = 1'b0,
    DDRSC_ST_BEAT1 = 1'b1
  } ddrsc_state_t;

  // one sample of the controller-driven pins
  typedef struct packed {
    logic cycle_load_n;
    logic read_sel;
    logic [`DDRSC_ADDR_W-1:0] addr;
    logic burst_start_low_bit;
    logic [`DDRSC_DATA_W-1:0] wdata;
    logic [`DDRSC_LANES-1:0] byte_lane_write_mask_n;
  } ddrsc_pins_t;

  // one read beat leaving through the fifo
  typedef struct packed {
    logic [`DDRSC_DATA_W-1:0] data;
    logic last;
  } ddrsc_beat_t;
endpackage

/* File: design/ddrsc_top.sv */
// burst-of-two ddr sram core: command decode, address load, masked writes, read fifo
//
// Contract
// - write masks are active low, sampled on each write beat, one per lane.
// - a masked lane keeps its stored contents; unmasked lanes are written.
// - x36 masks gate nine-bit lanes 8:0,17:9,26:18,35:27; x18 uses masks 0 and 1, x8 and x9 mask 0.
// - mask is captured on the same edge as the data beat it qualifies.
// - one shared address bus serves reads and writes, latched at load.
// - x8 and x9 force the internal low burst bit to zero; 22 address bits.
// - x18 and x36 load the burst counter from the low bit; 22 or 21 bits.
// - address inputs are ignored whenever no cycle is loaded.
// - at load, direction high means read, low means write.
// - storage is two equal arrays, one for each word of the burst.
// - load low starts a cycle; every transaction moves exactly two words.
`timescale 1ns/1ps
`default_nettype none

module ddrsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } ddrsc_fifo_st_t;

  ddrsc_fifo_st_t st_r;
  ddrsc_fifo_st_t st_nxt;
  // storage is not reset; out_data means nothing while out_valid is low
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_r.cnt != CW'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = mem_r[st_r.rp];
  assign level = st_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = (st_r.wp == PW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == PW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem_r[st_r.wp] <= in_data;
    end
  end
endmodule

// two-flop synchroniser for a level that arrives from outside the clock domain
module ddrsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // raw level in
  input wire logic [WIDTH-1:0] din,
  // settled level out, two edges late
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } ddrsc_sync_st_t;

  ddrsc_sync_st_t st_r;
  ddrsc_sync_st_t st_nxt;

  // only the second stage is visible; the first may still be settling
  assign dout = st_r.stage2;

  always_comb begin
    st_nxt.stage1 = din;
    st_nxt.stage2 = st_r.stage1;
  end

  // reset to the idle level so no false load follows reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r.stage1 <= RST_VAL;
      st_r.stage2 <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

module ddrsc_top #(
  parameter int ROW_W = `DDRSC_ROW_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // organisation strap
  input wire ddrsc_pkg::ddrsc_org_t org_sel,
  // controller pins, one beat per edge
  input wire ddrsc_pkg::ddrsc_pins_t pins,
  // read beats out
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [`DDRSC_DATA_W-1:0] rd_data,
  output logic rd_last,
  // room for one more whole read burst
  output logic load_ready
);
  import ddrsc_pkg::*;

  localparam int FIFO_D = `DDRSC_FIFO_DEPTH;
  localparam int FW = $bits(ddrsc_beat_t);
  // idle level of the pins: no load until the controller drives one
  localparam ddrsc_pins_t PINS_IDLE = '{cycle_load_n: 1'b1, default: '0};

  typedef struct packed {
    ddrsc_state_t state;
    logic rd;
    logic [ROW_W-1:0] row;
    logic bank1;
  } ddrsc_st_t;

  ddrsc_st_t st_r;
  ddrsc_st_t st_nxt;
  // one array per burst word
  logic [`DDRSC_DATA_W-1:0] bank0_mem [2**ROW_W];
  logic [`DDRSC_DATA_W-1:0] bank1_mem [2**ROW_W];

  ddrsc_pins_t p;
  logic [1:0] org_raw;
  ddrsc_org_t org_s;
  logic loading;
  logic beat_rd;
  logic beat_wr;
  logic beat_bank;
  logic [ROW_W-1:0] beat_row;
  logic [ROW_W-1:0] load_row;
  logic load_bank;
  logic wide;
  logic [`DDRSC_DATA_W-1:0] lane_en;
  logic [`DDRSC_DATA_W-1:0] old_word;
  logic [`DDRSC_DATA_W-1:0] new_word;
  logic [`DDRSC_DATA_W-1:0] org_bits;
  ddrsc_beat_t push_beat;
  ddrsc_beat_t pop_beat;
  logic push_valid;
  logic [$clog2(FIFO_D+1)-1:0] fifo_level;

  // pins and strap both come from outside; logic reads only the settled copies
  ddrsc_sync #(
    .WIDTH($bits(ddrsc_pins_t)),
    .RST_VAL(PINS_IDLE)
  ) u_pins_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .din(pins),
    .dout(p)
  );

  ddrsc_sync #(
    .WIDTH($bits(ddrsc_org_t)),
    .RST_VAL(2'h0)
  ) u_org_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .din(org_sel),
    .dout(org_raw)
  );

  // the strap is a level too; the cast only restores its type
  assign org_s = ddrsc_org_t'(org_raw);
  assign wide = (org_s == DDRSC_ORG_X18) || (org_s == DDRSC_ORG_X36);
  // a load is only honoured outside a running burst
  assign loading = !p.cycle_load_n && (st_r.state == DDRSC_ST_IDLE);

  always_comb begin
    // wide parts carry one fewer row bit on the x36 organisation
    load_row = p.addr[ROW_W-1:0];
    if (org_s == DDRSC_ORG_X36) begin
      load_row = ROW_W'(p.addr[`DDRSC_ADDR_W36-1:0]);
    end
    load_bank = wide ? p.burst_start_low_bit : 1'b0;
  end

  // beat 0 is the load edge itself, beat 1 the edge after
  assign beat_row = loading ? load_row : st_r.row;
  assign beat_bank = loading ? load_bank : st_r.bank1;
  assign beat_rd = loading ? p.read_sel : (st_r.state == DDRSC_ST_BEAT1) && st_r.rd;
  assign beat_wr = loading ? !p.read_sel : (st_r.state == DDRSC_ST_BEAT1) && !st_r.rd;

  always_comb begin
    unique case (org_s)
      DDRSC_ORG_X8: org_bits = `DDRSC_DATA_W'(16'h00FF);
      DDRSC_ORG_X9: org_bits = `DDRSC_DATA_W'(16'h01FF);
      DDRSC_ORG_X18: org_bits = `DDRSC_DATA_W'(20'h3_FFFF);
      DDRSC_ORG_X36: org_bits = 36'hF_FFFF_FFFF;
    endcase
    // mask sampled with the very beat it qualifies
    for (int i = 0; i < `DDRSC_LANES; i++) begin
      lane_en[i*`DDRSC_LANE_W +: `DDRSC_LANE_W] =
        {`DDRSC_LANE_W{!p.byte_lane_write_mask_n[i]}};
    end
    lane_en = lane_en & org_bits;
    old_word = beat_bank ? bank1_mem[beat_row] : bank0_mem[beat_row];
    // masked lanes keep the stored bits
    new_word = (p.wdata & lane_en) | (old_word & ~lane_en);
  end

  // each beat of a write lands on its own edge, beat 0 first
  always_ff @(posedge ref_clk) begin
    if (beat_wr) begin
      if (beat_bank) begin
        bank1_mem[beat_row] <= new_word;
      end else begin
        bank0_mem[beat_row] <= new_word;
      end
    end
  end

  // read beats queue up; the controller watches load_ready before loading reads
  assign push_beat.data = old_word & org_bits;
  assign push_beat.last = (st_r.state == DDRSC_ST_BEAT1);
  assign push_valid = beat_rd;
  assign load_ready = (fifo_level <= ($clog2(FIFO_D+1))'(FIFO_D - `DDRSC_BURST_LEN));

  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      DDRSC_ST_IDLE: begin
        // address pins only matter at a load
        if (loading) begin
          st_nxt.state = DDRSC_ST_BEAT1;
          st_nxt.rd = p.read_sel;
          st_nxt.row = load_row;
          // one-bit counter: the partner word sits in the other array
          st_nxt.bank1 = ~load_bank;
        end
      end
      DDRSC_ST_BEAT1: begin
        st_nxt.state = DDRSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ddrsc_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_D)
  ) u_rd_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(push_valid),
    // a full fifo refuses the push; load_ready keeps the controller clear of that
    .in_ready(),
    .in_data(push_beat),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(pop_beat),
    .level(fifo_level)
  );

  assign rd_data = pop_beat.data;
  assign rd_last = pop_beat.last;
endmodule

`default_nettype wire

/* File: verification/ddrsc_asserts.sv */
// port checker for the sram front end
`timescale 1ns/1ps
`default_nettype none
module ddrsc_asserts import ddrsc_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // strap and controller pins
  input wire ddrsc_pkg::ddrsc_org_t org_sel,
  input wire ddrsc_pkg::ddrsc_pins_t pins,
  // read side
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [35:0] rd_data,
  input wire logic rd_last,
  input wire logic load_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence pop_first;
    rd_valid && rd_ready && !rd_last;
  endsequence
  sequence pop_second;
    rd_valid && rd_ready && rd_last;
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) srst |=> !rd_valid && load_ready)
    else $error("read side not idle after reset");
  read_start_a: assert property ($rose(rd_valid) |-> $past(!pins.cycle_load_n && pins.read_sel, 3))
    else $error("read beat without a read load");
  first_beat_a: assert property ($rose(rd_valid) |-> !rd_last)
    else $error("burst began with its last beat");
  beat_pair_a: assert property (pop_first |=> rd_valid && rd_last)
    else $error("second beat missing");
  pair_alt_a: assert property (pop_second |=> !rd_valid || !rd_last)
    else $error("two last beats in a row");
  beat_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("stalled beat changed");
  room_free_a: assert property (!rd_valid |-> load_ready)
    else $error("no room while empty");
  narrow_x8_a: assert property (rd_valid && org_sel == DDRSC_ORG_X8 |-> rd_data[35:8] == 0)
    else $error("x8 beat wider than eight bits");
  narrow_x18_a: assert property (rd_valid && org_sel == DDRSC_ORG_X18 |-> rd_data[35:18] == 0)
    else $error("x18 beat too wide");
endmodule
bind ddrsc_top ddrsc_asserts u_chk (.ref_clk(ref_clk), .srst(srst), .org_sel(org_sel),
  .pins(pins), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
  .rd_last(rd_last), .load_ready(load_ready));
`default_nettype wire

/* File: verification/ddrsc_ctrl_model.sv */
// memory controller model driving the sram pins at the falling edge
`timescale 1ns/1ps
`default_nettype none
module ddrsc_ctrl_model import ddrsc_pkg::*; (
  input wire logic ref_clk,
  output var ddrsc_pkg::ddrsc_pins_t pins
);
  initial pins = 65'h1_0000_0000_0000_0000;
  // bb skips the idle cycle so the next load follows beat 1 directly
  task automatic burst(input logic rd, input logic [21:0] a, input logic lo,
      input logic [71:0] d, input logic [7:0] m, input logic bb);
    @(negedge ref_clk);
    pins <= {1'b0, rd, a, lo, d[35:0], m[3:0]};
    @(negedge ref_clk);
    // address lines carry the inverse on beat 1; the idle cycle drives them true again
    pins <= {1'b1, ~rd, ~a, ~lo, d[71:36], m[7:4]};
    if (!bb) begin
      @(negedge ref_clk);
      pins <= {1'b1, rd, a, lo, ~d[71:36], ~m[7:4]};
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/ddrsc_top_tb.sv */
// self-checking bench for the sram front end
`timescale 1ns/1ps
`default_nettype none
module ddrsc_top_tb;
  import ddrsc_pkg::*;
  typedef struct packed {ddrsc_org_t org; logic lo; logic rlo; logic [7:0] m;} ddrsc_row_t;
  localparam logic [71:0] BASE = 72'h12_3456_789A_BCDE_F012;
  localparam logic [71:0] DATA = 72'hED_CBA9_8765_4321_0FED;
  ddrsc_row_t rows [4] = '{'{DDRSC_ORG_X8, 1'b1, 1'b0, 8'h10}, '{DDRSC_ORG_X9, 1'b0, 1'b1, 8'h01},
    '{DDRSC_ORG_X18, 1'b0, 1'b1, 8'h21}, '{DDRSC_ORG_X36, 1'b1, 1'b1, 8'h5A}};
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic rd_ready = 1'b1;
  ddrsc_org_t org_sel = DDRSC_ORG_X8;
  ddrsc_pins_t pins;
  logic rd_valid, rd_last, load_ready, l0, l1, sw;
  logic [35:0] rd_data, v0, v1, e0, e1;
  int num_errors = 0;
  int samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  ddrsc_ctrl_model ctl (.ref_clk(ref_clk), .pins(pins));
  ddrsc_top #(.ROW_W(6)) dut (.ref_clk(ref_clk), .srst(srst), .org_sel(org_sel), .pins(pins),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .rd_last(rd_last),
    .load_ready(load_ready));
  function automatic logic [35:0] expw(ddrsc_org_t o, logic [35:0] b, logic [35:0] d,
      logic [3:0] m);
    logic [35:0] r;
    for (int i = 0; i < 4; i++) r[9*i +: 9] = m[i] ? b[9*i +: 9] : d[9*i +: 9];
    return r & (o == DDRSC_ORG_X36 ? 36'hF_FFFF_FFFF : o == DDRSC_ORG_X18 ? 36'h0_0003_FFFF :
      o == DDRSC_ORG_X9 ? 36'h0_0000_01FF : 36'h0_0000_00FF);
  endfunction
  task automatic chk(string n, logic [35:0] e, logic [35:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic get(output logic [35:0] v, output logic l);
    int t;
    t = 0;
    @(negedge ref_clk);
    while (rd_valid !== 1'b1 && t < 30) begin
      @(negedge ref_clk);
      t++;
    end
    if (rd_valid !== 1'b1) begin
      num_errors++;
      $display("BAD rd_valid expected 1 seen %b", rd_valid);
    end
    v = rd_data;
    l = rd_last;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #50us;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    chk("load_ready", 1, load_ready);
    for (int i = 0; i < 4; i++) begin
      org_sel = rows[i].org;
      repeat (3) @(negedge ref_clk);
      ctl.burst(0, 22'(i + 1), rows[i].lo, BASE, 8'h00, 0);
      ctl.burst(0, 22'(i + 1), rows[i].lo, DATA, rows[i].m, 0);
      ctl.burst(1, 22'(i + 1), rows[i].rlo, BASE, 8'hFF, 0);
      get(v0, l0);
      get(v1, l1);
      sw = rows[i].org[1] && (rows[i].rlo != rows[i].lo);
      e0 = expw(rows[i].org, BASE[35:0], DATA[35:0], rows[i].m[3:0]);
      e1 = expw(rows[i].org, BASE[71:36], DATA[71:36], rows[i].m[7:4]);
      chk("beat0", sw ? e1 : e0, v0);
      chk("beat1", sw ? e0 : e1, v1);
      chk("last", 2'b01, {l0, l1});
      $display("row %0d done", i);
    end
    // fifo stall: let the last row's second beat pop, then fill all four places
    @(negedge ref_clk);
    rd_ready = 1'b0;
    ctl.burst(1, 22'd4, 1'b1, BASE, 8'hFF, 1);
    ctl.burst(1, 22'd4, 1'b1, BASE, 8'hFF, 0);
    repeat (4) @(negedge ref_clk);
    chk("full", 2'b10, {rd_valid, load_ready});
    rd_ready = 1'b1;
    for (int k = 0; k < 4; k++) begin
      chk("drain_valid", 1, rd_valid);
      chk("drain", k[0] ? e1 : e0, rd_data);
      chk("drain_last", k[0], rd_last);
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    chk("empty", 2'b01, {rd_valid, load_ready});
    $display("stall done");
    // reset in mid-run clears a pending burst
    rd_ready = 1'b0;
    ctl.burst(1, 22'd4, 1'b1, BASE, 8'hFF, 0);
    repeat (3) @(negedge ref_clk);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    chk("reset", 2'b01, {rd_valid, load_ready});
    rd_ready = 1'b1;
    ctl.burst(1, 22'd4, 1'b1, BASE, 8'hFF, 0);
    get(v0, l0);
    get(v1, l1);
    chk("rst_beat0", e0, v0);
    chk("rst_beat1", e1, v1);
    chk("rst_last", 2'b01, {l0, l1});
    $display("reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
